/* File: core/icc_map.svh */
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH

// Register byte addresses
`define ICC_CTRL_OFS      12'h000
`define ICC_FLAG_OFS      12'h010
`define ICC_FSET_OFS      12'h020
`define ICC_ENAB_OFS      12'h030
`define ICC_VBASE_OFS     12'h040
`define ICC_VSPACE_OFS    12'h044
`define ICC_WIN_OFS       12'h048
`define ICC_PRIO_OFS      12'h100
`define ICC_PRIO_END      12'h1b8

// Control register fields
`define ICC_MULTI_VECTOR_SELECT_BIT      12
`define ICC_PROX_LSB      8
`define ICC_EDGE_LSB      0
`define ICC_CTRL_MASK     32'h0000_171f

// Priority register fields
`define ICC_PRI_LSB       2
`define ICC_SUB_LSB       0

// Reset values
`define ICC_CTRL_RST      32'h0000_0000
`define ICC_VBASE_RST     32'h0000_0000
`define ICC_VSPACE_RST    16'h0000

// Sizes
`define ICC_NSRC          76
`define ICC_NVEC          46
`define ICC_NEXT          5

`endif

/* File: core/icc_pkg.sv */
package icc_pkg;

	typedef struct packed {
		logic [2:0] pri;
		logic [1:0] sub;
	} icc_prio_t;

	typedef struct packed {
		logic       valid;
		logic [5:0] vector;
		logic [2:0] pri;
		logic [1:0] sub;
	} icc_core_req_t;

	typedef struct packed {
		logic       multi_vector_select;
		logic [2:0] prox;
		logic [4:0] edgePol;
	} icc_ctrl_t;

endpackage

/* File: core/icc_ext_edge.sv */
`timescale 1ns/10ps
module icc_ext_edge (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	input  wire logic rising,
	output logic      pulse
);
	logic syncA;
	logic syncB;
	logic last;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			syncA <= 1'b0;
			syncB <= 1'b0;
			last  <= 1'b0;
			pulse <= 1'b0;
		end else begin
			syncA <= pin;
			syncB <= syncA;
			last  <= syncB;
			pulse <= rising ? (syncB & ~last) : (~syncB & last);
		end
	end
endmodule

/* File: core/icc_top.sv */
// Function
// - Vector-mode bit set gives multi-vector mode, clear gives single-vector.
// - Threshold codes 010-111 let group priority at or below code start timer.
// - Threshold code 001 lets only group priority one start the timer.
// - Threshold code 000 disables the proximity timer entirely.
// - Each external input has a polarity bit: 1 rising, 0 falling edge.
// - Up to 76 sources are mapped onto at most 46 vectors.
// - Each vector gets one of seven priorities and four subpriorities.
// - Software can raise any source like a hardware event.
// - Pending events are arbitrated; only the winner goes to the core.
// - Unimplemented control bits read zero and ignore writes.
// - Software sets vector table base and spacing between entries.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "icc_map.svh"
module icc_top
	import icc_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic [`ICC_NSRC-1:0] hwEvent,
	input  wire logic [`ICC_NEXT-1:0] extPin,
	output icc_core_req_t             coreReq,
	output logic      [31:0]          vectorAddr,
	output logic                      proxStart,
	output logic                      irq
);
	localparam int NSRC = `ICC_NSRC;
	localparam int NVEC = `ICC_NVEC;
	localparam int NEXT = `ICC_NEXT;

	icc_ctrl_t                ctrl;
	logic      [NSRC-1:0]     flag;
	logic      [NSRC-1:0]     enable;
	logic      [31:0]         vecBase;
	logic      [15:0]         vecSpace;
	icc_prio_t                prio [NVEC];
	logic      [NEXT-1:0]     extPulse;
	logic      [NSRC-1:0]     srcEvt;
	logic      [NSRC-1:0]     swSet;
	logic      [NSRC-1:0]     swClr;
	logic      [95:0]         flagPad;
	logic      [95:0]         enabPad;
	logic      [NVEC-1:0]     vecPend;
	icc_core_req_t            next_win;
	logic      [31:0]         next_prdata;
	logic                     next_slverr;
	logic                     wrEn;
	logic                     setup;
	logic                     hitPrio;
	logic      [5:0]          prioIdx;
	logic      [1:0]          wordIdx;
	logic                     proxHit;

	////////////////////////////////////////////////////////////////////////
	// External edge detectors

	for (genvar g = 0; g < NEXT; g++) begin : gEdge
		icc_ext_edge uEdge (
			.clk    (clk),
			.rst_n  (rst_n),
			.pin    (extPin[g]),
			.rising (ctrl.edgePol[g]),
			.pulse  (extPulse[g])
		);
	end

	// External inputs take the lowest source numbers
	assign srcEvt = {hwEvent[NSRC-1:NEXT], extPulse};

	////////////////////////////////////////////////////////////////////////
	// APB decode

	assign setup   = psel & ~penable;
	assign wrEn    = psel & penable & pready & pwrite;
	assign wordIdx = paddr[3:2];
	assign hitPrio = (paddr >= `ICC_PRIO_OFS) && (paddr < `ICC_PRIO_END);
	assign prioIdx = 6'((paddr - `ICC_PRIO_OFS) >> 2);

	assign flagPad = {20'h0_0000, flag};
	assign enabPad = {20'h0_0000, enable};

	// One wait-free access phase: ready rises the cycle after setup
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup & next_slverr;
			prdata  <= setup ? next_prdata : 32'h0000_0000;
		end
	end

	always_comb begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		if (hitPrio) begin
			next_prdata[4:0] = prio[prioIdx];
		end else if (paddr[11:4] == `ICC_FLAG_OFS >> 4 ||
				paddr[11:4] == `ICC_FSET_OFS >> 4) begin
			if (wordIdx == 2'h3)
				next_slverr = 1'b1;
			else
				next_prdata = flagPad[32*wordIdx +: 32];
		end else if (paddr[11:4] == `ICC_ENAB_OFS >> 4) begin
			if (wordIdx == 2'h3)
				next_slverr = 1'b1;
			else
				next_prdata = enabPad[32*wordIdx +: 32];
		end else begin
			case (paddr)
				`ICC_CTRL_OFS: begin
					next_prdata[`ICC_MULTI_VECTOR_SELECT_BIT] = ctrl.multi_vector_select;
					next_prdata[`ICC_PROX_LSB +: 3] = ctrl.prox;
					next_prdata[`ICC_EDGE_LSB +: NEXT] = ctrl.edgePol;
				end
				`ICC_VBASE_OFS:  next_prdata = vecBase;
				`ICC_VSPACE_OFS: next_prdata = {16'h0000, vecSpace};
				`ICC_WIN_OFS: begin
					next_prdata[11:0] = coreReq;
				end
				default:         next_slverr = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control, base and spacing

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= icc_ctrl_t'(9'h000);
		end else if (wrEn && paddr == `ICC_CTRL_OFS) begin
			// Only implemented bits are captured
			ctrl.multi_vector_select    <= pwdata[`ICC_MULTI_VECTOR_SELECT_BIT];
			ctrl.prox    <= pwdata[`ICC_PROX_LSB +: 3];
			ctrl.edgePol <= pwdata[`ICC_EDGE_LSB +: NEXT];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vecBase  <= `ICC_VBASE_RST;
			vecSpace <= `ICC_VSPACE_RST;
		end else if (wrEn) begin
			if (paddr == `ICC_VBASE_OFS)
				vecBase <= pwdata;
			if (paddr == `ICC_VSPACE_OFS)
				vecSpace <= pwdata[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Priority table

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int v = 0; v < NVEC; v++)
				prio[v] <= icc_prio_t'(5'h00);
		end else if (wrEn && hitPrio) begin
			prio[prioIdx].pri <= pwdata[`ICC_PRI_LSB +: 3];
			prio[prioIdx].sub <= pwdata[`ICC_SUB_LSB +: 2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source flags and enables

	always_comb begin
		swSet = '0;
		swClr = '0;
		if (wrEn && wordIdx != 2'h3) begin
			// Widen first so words 1 and 2 are not shifted out
			if (paddr[11:4] == `ICC_FSET_OFS >> 4)
				swSet = NSRC'({64'h0, pwdata} << (32 * wordIdx));
			if (paddr[11:4] == `ICC_FLAG_OFS >> 4)
				swClr = NSRC'({64'h0, pwdata} << (32 * wordIdx));
		end
	end

	// A same-cycle event beats the write-one clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			flag <= '0;
		else
			flag <= (flag & ~swClr) | srcEvt | swSet;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			enable <= '0;
		end else if (wrEn && wordIdx != 2'h3 &&
				paddr[11:4] == `ICC_ENAB_OFS >> 4) begin
			for (int b = 0; b < 32; b++)
				if (32 * int'(wordIdx) + b < NSRC)
					enable[32 * int'(wordIdx) + b] <= pwdata[b];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Arbitration

	// Sources beyond the vector count share vectors, folded by modulo
	always_comb begin
		vecPend = '0;
		for (int s = 0; s < NSRC; s++)
			vecPend[s % NVEC] = vecPend[s % NVEC] |
				(flag[s] & enable[s]);
	end

	// Priority 0 means off; ties go to the lower vector number
	always_comb begin
		next_win = '0;
		for (int v = 0; v < NVEC; v++) begin
			if (vecPend[v] && prio[v].pri != 3'h0 &&
					(!next_win.valid ||
					prio[v].pri > next_win.pri ||
					(prio[v].pri == next_win.pri &&
					prio[v].sub > next_win.sub))) begin
				next_win.valid  = 1'b1;
				next_win.vector = 6'(v);
				next_win.pri    = prio[v].pri;
				next_win.sub    = prio[v].sub;
			end
		end
		if (!ctrl.multi_vector_select)
			next_win.vector = 6'h00;
	end

	// Code 000 never matches since group priority 0 is never a winner
	assign proxHit = next_win.valid && ctrl.prox != 3'h0 &&
		next_win.pri <= ctrl.prox;

	////////////////////////////////////////////////////////////////////////
	// Outputs to the core

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			coreReq    <= '0;
			vectorAddr <= 32'h0000_0000;
			proxStart  <= 1'b0;
			irq        <= 1'b0;
		end else begin
			coreReq    <= next_win;
			// Single-vector mode always lands on the base entry
			vectorAddr <= vecBase +
				32'(next_win.vector) * 32'(vecSpace);
			// Fires once when a qualifying winner appears or differs from the last in vector or group priority
			proxStart  <= proxHit && (!coreReq.valid ||
				coreReq.vector != next_win.vector ||
				coreReq.pri != next_win.pri);
			irq        <= |(flag & enable);
		end
	end
endmodule

/* File: verification/icc_top_assertions.sv */
`timescale 1ns/10ps
module icc_top_assertions
	import icc_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire logic          psel,
	input wire logic          penable,
	input wire logic          pwrite,
	input wire logic [11:0]   paddr,
	input wire logic [31:0]   pwdata,
	input wire logic [31:0]   prdata,
	input wire logic          pready,
	input wire logic          pslverr,
	input wire logic [75:0]   hwEvent,
	input wire logic [4:0]    extPin,
	input wire icc_core_req_t coreReq,
	input wire logic [31:0]   vectorAddr,
	input wire logic          proxStart,
	input wire logic          irq
);
	logic [12:0] ctl;
	logic [31:0] base;
	wire         wr = psel && penable && pready && pwrite;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ctl <= 13'h0;
		else if (wr && paddr == 12'h000) ctl <= pwdata[12:0];
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) base <= 32'h0;
		else if (wr && paddr == 12'h040) base <= pwdata;
	end
	////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	ready_after_setup_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_read_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 0))
		else $error("bad error response");
	ctrl_unused_a: assert property (pready && !pwrite && paddr == 12'h000
		|-> (prdata & ~32'h171f) == 0) else $error("control spare bits set");
	winner_legal_a: assert property (coreReq.valid
		|-> coreReq.pri != 0 && coreReq.vector < 46) else $error("bad winner");
	single_vector_a: assert property (coreReq.valid && !ctl[12]
		&& !$past(ctl[12]) && !$past(ctl[12], 2) |-> coreReq.vector == 0)
		else $error("vector not zero in single mode");
	prox_gate_a: assert property (proxStart
		|-> $past(ctl[10:8]) != 0 && coreReq.pri <= $past(ctl[10:8]))
		else $error("trigger not allowed");
	vector_base_a: assert property (coreReq.valid && coreReq.vector == 0
		|-> vectorAddr == $past(base)) else $error("vector address off base");
	cover property (proxStart);
	cover property (coreReq.valid && ctl[12]);
	cover property (pslverr);
endmodule

/* File: verification/icc_core_model.sv */
`timescale 1ns/10ps
module icc_core_model
	import icc_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst_n,
	input wire icc_core_req_t coreReq,
	input wire logic          proxStart,
	output logic [7:0]        pulseCount
);
	// Core has no acknowledge path, so it only counts trigger pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) pulseCount <= 8'h0;
		else if (proxStart && coreReq.valid) pulseCount <= pulseCount + 8'h1;
	end
endmodule

/* File: verification/tb.sv */
`timescale 1ns/10ps
module tb
	import icc_pkg::*;
;
	logic          clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0]   paddr = 12'h0;
	logic [31:0]   pwdata = 32'h0, prdata, vectorAddr, r;
	logic [75:0]   hwEvent = 76'h0;
	logic [4:0]    extPin = 5'h0;
	logic          pready, pslverr, proxStart, irq;
	logic [7:0]    pulses;
	logic [32:0]   expQ[$];
	icc_core_req_t coreReq;
	int            num_errors = 0, samples_checked = 0, seed = 32'h48c42a74;
	always #5 clk = ~clk;
	icc_top icc_top_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hwEvent(hwEvent), .extPin(extPin), .coreReq(coreReq),
		.vectorAddr(vectorAddr), .proxStart(proxStart), .irq(irq));
	icc_core_model icc_core_model_inst (.clk(clk), .rst_n(rst_n),
		.coreReq(coreReq), .proxStart(proxStart), .pulseCount(pulses));
	////////////////////////////////////////
	task chk(input string n, input logic [32:0] e, input logic [32:0] g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// Reads note {error, data} expected; the monitor below compares
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic e = 1'b0);
		if (!w) expQ.push_back({e, d});
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// Request stands until ready is seen high at a rising edge
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			chk("read data", expQ.pop_front(), {pslverr, prdata});
		end
	end
	task settle;
		repeat (3) @(posedge clk);
	endtask
	task wrap_up;
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		#100000;
		num_errors++;
		wrap_up;
	end
	////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		apb(0, 12'h000, 32'h0);
		apb(0, 12'h01c, 32'h0, 1'b1);
		apb(1, 12'h000, 32'hffffffff);
		apb(0, 12'h000, 32'h171f);
		r = $random(seed);
		apb(1, 12'h040, r);
		apb(0, 12'h040, r);
		apb(1, 12'h044, r);
		apb(0, 12'h044, {16'h0, r[15:0]});
		apb(1, 12'h1b4, r);
		apb(0, 12'h1b4, {27'h0, r[4:0]});
		apb(1, 12'h040, 32'h1000);
		apb(1, 12'h044, 32'h20);
		apb(1, 12'h000, 32'h1500);
		apb(1, 12'h128, 32'h18);
		apb(1, 12'h11c, 32'h16);
		apb(1, 12'h030, 32'h400);
		apb(1, 12'h034, 32'h200000);
		apb(1, 12'h020, 32'h400);
		hwEvent[53] <= 1'b1;
		@(posedge clk);
		hwEvent <= 76'h0;
		settle;
		apb(0, 12'h048, 32'h958);
		chk("vector address", 32'h1140, vectorAddr);
		chk("winner", 33'h958, coreReq);
		chk("irq", 1, irq);
		apb(1, 12'h010, 32'h400);
		settle;
		apb(0, 12'h048, 32'h8f6);
		chk("trigger count", 1, pulses);
		apb(1, 12'h014, 32'h200000);
		apb(0, 12'h014, 32'h0);
		settle;
		chk("irq", 0, irq);
		apb(1, 12'h000, 32'h1000);
		apb(1, 12'h128, 32'h4);
		apb(1, 12'h020, 32'h400);
		settle;
		chk("trigger count", 1, pulses);
		apb(1, 12'h010, 32'h400);
		apb(1, 12'h000, 32'h1100);
		apb(1, 12'h020, 32'h400);
		settle;
		chk("trigger count", 2, pulses);
		apb(1, 12'h000, 32'h0100);
		settle;
		apb(0, 12'h048, 32'h804);
		chk("vector address", 32'h1000, vectorAddr);
		apb(1, 12'h030, 32'h0);
		settle;
		chk("irq", 0, irq);
		apb(0, 12'h010, 32'h400);
		apb(1, 12'h030, 32'h400);
		settle;
		chk("irq", 1, irq);
		apb(1, 12'h010, 32'h400);
		for (int i = 0; i < 5; i++) begin
			r = $random(seed);
			apb(1, 12'h000, {31'h0, r[0]} << i);
			extPin[i] <= ~r[0];
			repeat (6) @(posedge clk);
			apb(1, 12'h010, 32'h1f);
			extPin[i] <= r[0];
			repeat (6) @(posedge clk);
			apb(0, 12'h010, 32'h1 << i);
		end
		wrap_up;
	end
endmodule
bind icc_top icc_top_assertions icc_top_assertions_inst (.clk(clk),
	.rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .hwEvent(hwEvent), .extPin(extPin),
	.coreReq(coreReq), .vectorAddr(vectorAddr), .proxStart(proxStart),
	.irq(irq));
